// >>> inc/mhd_pkg.sv
package mhd_pkg;

  // ---------------------------------------------------------------
  // host bus commands
  // ---------------------------------------------------------------
  localparam logic [1:0] CMD_IDLE  = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ  = 2'h2;

  // ---------------------------------------------------------------
  // descriptor layout
  // ---------------------------------------------------------------
  localparam int OWN_BIT        = 31;
  localparam int CHAIN_BIT      = 24;
  localparam int SIZE2_HI       = 21;
  localparam int SIZE2_LO       = 11;
  localparam int SIZE1_HI       = 10;
  localparam int SIZE1_LO       = 0;
  localparam int LEN_LO         = 16;
  localparam logic [1:0] DESC_LAST_WORD = 2'h2;
  localparam logic [31:0] DESC_BYTES    = 32'h0000_0010;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // states, gray along the forward path; DWB to IDLE and WAIT to MAIN change more than one bit
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    RX_IDLE   = 3'h0,
    RX_DREAD  = 3'h1,
    RX_PAUSE  = 3'h3,
    RX_WRITE  = 3'h2,
    RX_STAT   = 3'h6,
    RX_DWB    = 3'h7
  } mhd_rx_state_type;

  typedef enum logic [2:0] {
    DS_IDLE    = 3'h0,
    DS_MAIN    = 3'h1,
    DS_READ    = 3'h3,
    DS_WAIT    = 3'h2,
    DS_SUSPEND = 3'h6
  } mhd_ds_state_type;

  // ---------------------------------------------------------------
  // host bus request carrier
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  cmd;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        final_word;
  } mhd_host_req_type;

endpackage

// >>> verilog/mhd_top.sv
// Behaviour
// - rx engine leaves idle for descriptor read when no pointer valid, granted
// - descriptor read ends in write pause on valid word with count 2
// - write pause returns idle when descriptor not usable
// - write pause enters buffer write on fifo data, nothing pending, grant
// - last burst word with frame done moves to status state
// - full buffer goes to buffer two if allowed, else descriptor write-back
// - burst end without frame or buffer end returns to write pause
// - status state goes to write-back once receive fifo not empty
// - write-back ends on grant plus host data valid, back to idle
// - fetch engine leaves idle on inverted receive start control
// - fetch main starts descriptor read once descriptor access granted
// - first word bit 31 set waits, clear suspends
// - fetch wait returns to main on new descriptor enabled
// - suspend resumes on internal poll event or poll demand
// - descriptor request raised when needed, dropped when data loads pointer
// - next descriptor address advanced by 16 bytes plus 5-bit word step
// - data bursts limited by 6-bit burst length
// - list base is 30-bit word address
// - each engine has a free-clock computed clock gate enable
// - checksum and pad indications only on frame start word
// - frame error indication only on frame end word
// - jabber timeout flagged, host then issues software reset
`timescale 1ns/100ps
`default_nettype none

module mhd_top (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rstn,
  output var mhd_pkg::mhd_host_req_type o_host_req,
  input  wire logic                     i_host_read_data_valid,
  input  wire logic [31:0]              i_host_read_word,
  input  wire logic                     i_recv_fifo_empty,
  input  wire logic                     i_recv_fifo_final_read,
  input  wire logic [31:0]              i_recv_fifo_word,
  input  wire logic                     i_recv_fifo_eof,
  output logic                          o_recv_fifo_read,
  input  wire logic                     i_receive_start_control,
  input  wire logic                     i_receive_poll_demand,
  input  wire logic                     i_recv_internal_poll_event,
  input  wire logic [29:0]              i_receive_list_base,
  input  wire logic [4:0]               i_desc_address_step,
  input  wire logic [5:0]               i_burst_length_limit,
  input  wire logic                     i_recv_unavail_clear,
  output logic                          o_receive_buffer_unavailable_flag,
  output logic                          o_recv_desc_request,
  output logic                          o_recv_engine_clock_gate,
  output logic                          o_desc_fetch_clock_gate,
  output logic                          o_xmit_clock_gate,
  input  wire logic                     i_xmit_word_valid,
  output logic                          o_xmit_word_ready,
  input  wire logic [31:0]              i_xmit_word,
  input  wire logic                     i_xmit_sof,
  input  wire logic                     i_xmit_eof,
  input  wire logic                     i_xmit_want_checksum,
  input  wire logic                     i_xmit_want_pad,
  input  wire logic                     i_xmit_error,
  input  wire logic                     i_xmit_fifo_full,
  output logic                          o_xmit_fifo_write,
  output logic [31:0]                   o_xmit_fifo_word,
  output logic                          o_xmit_fifo_sof,
  output logic                          o_xmit_fifo_eof,
  output logic                          o_xmit_insert_checksum,
  output logic                          o_xmit_insert_pad,
  output logic                          o_xmit_frame_error_flag,
  input  wire logic                     i_xmit_jabber_event,
  input  wire logic                     i_soft_reset,
  output logic                          o_xmit_jabber_timeout_flag
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;

  // two-stage release of the asynchronous reset
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  wire rst_n = rst_sync_reg;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  mhd_pkg::mhd_rx_state_type rx_state_reg;
  mhd_pkg::mhd_rx_state_type rx_state_next;
  mhd_pkg::mhd_ds_state_type ds_state_reg;
  mhd_pkg::mhd_ds_state_type ds_state_next;
  logic [31:0] ds_addr_reg;
  logic        ptr_valid_reg;
  logic        ru_flag_reg;
  logic [31:0] desc_status_reg;
  logic [31:0] desc_ctrl_reg;
  logic [31:0] buf_addr_reg;
  logic [1:0]  dword_cnt_reg;
  logic [5:0]  burst_cnt_reg;
  logic [10:0] buff_cnt_reg;
  logic [13:0] frame_words_reg;
  logic        cur_buff_reg;
  logic        slot_valid_reg;
  logic [31:0] slot_word_reg;
  logic        slot_eof_reg;
  logic        frame_done_reg;
  logic        own_rx_reg;
  logic        own_ds_reg;

  // ---------------------------------------------------------------
  // arbiter
  // ---------------------------------------------------------------
  // descriptor fetch wins a free bus; an owner keeps it while asking
  wire rx_req   = (rx_state_reg == mhd_pkg::RX_IDLE && !ptr_valid_reg)
               || (rx_state_reg == mhd_pkg::RX_PAUSE && desc_status_reg[31]
                   && !i_recv_fifo_empty)
               || rx_state_reg == mhd_pkg::RX_DREAD
               || rx_state_reg == mhd_pkg::RX_WRITE
               || rx_state_reg == mhd_pkg::RX_DWB;
  wire ds_req   = ds_state_reg == mhd_pkg::DS_MAIN
               || ds_state_reg == mhd_pkg::DS_READ;
  wire bus_free = !own_rx_reg && !own_ds_reg;
  wire ds_grant = own_ds_reg || (bus_free && ds_req);
  wire rx_grant = own_rx_reg || (bus_free && !ds_req && rx_req);

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      own_rx_reg <= 1'b0;
      own_ds_reg <= 1'b0;
    end else begin
      own_rx_reg <= rx_grant && rx_req;
      own_ds_reg <= ds_grant && ds_req;
    end
  end

  // ---------------------------------------------------------------
  // receive descriptor fetch engine
  // ---------------------------------------------------------------
  // base address
  wire [31:0] list_base = {i_receive_list_base, 2'b00};
  wire [31:0] step_bytes = {25'h0, i_desc_address_step, 2'b00};
  wire [31:0] next_addr  = ds_addr_reg + mhd_pkg::DESC_BYTES + step_bytes;
  wire        ds_word_in = ds_state_reg == mhd_pkg::DS_READ
                        && i_host_read_data_valid;
  wire        new_desc_enabled = rx_state_reg == mhd_pkg::RX_DWB
                              && rx_grant && i_host_read_data_valid;

  // fetch state transitions
  always_comb begin
    ds_state_next = ds_state_reg;
    unique case (ds_state_reg)
      mhd_pkg::DS_IDLE:
        if (!i_receive_start_control) ds_state_next = mhd_pkg::DS_MAIN;
      mhd_pkg::DS_MAIN:
        if (ds_grant) ds_state_next = mhd_pkg::DS_READ;
      mhd_pkg::DS_READ:
        if (ds_word_in) begin
          ds_state_next = i_host_read_word[mhd_pkg::OWN_BIT]
                        ? mhd_pkg::DS_WAIT : mhd_pkg::DS_SUSPEND;
        end
      mhd_pkg::DS_WAIT:
        if (new_desc_enabled) ds_state_next = mhd_pkg::DS_MAIN;
      mhd_pkg::DS_SUSPEND:
        if (i_recv_internal_poll_event || i_receive_poll_demand) begin
          ds_state_next = mhd_pkg::DS_MAIN;
        end
      default: ds_state_next = mhd_pkg::DS_IDLE;
    endcase
  end

  // fetch registers, pointer and unavailable flag
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ds_state_reg  <= mhd_pkg::DS_IDLE;
      ds_addr_reg   <= mhd_pkg::ADDR_RESET;
      ptr_valid_reg <= 1'b0;
      ru_flag_reg   <= 1'b0;
    end else begin
      ds_state_reg <= ds_state_next;
      if (ds_state_reg == mhd_pkg::DS_IDLE) ds_addr_reg <= list_base;
      else if (ds_state_reg == mhd_pkg::DS_WAIT && new_desc_enabled)
        ds_addr_reg <= next_addr;
      if (ds_word_in) ptr_valid_reg <= i_host_read_word[mhd_pkg::OWN_BIT];
      else if (new_desc_enabled) ptr_valid_reg <= 1'b0;
      if (ds_word_in && !i_host_read_word[mhd_pkg::OWN_BIT])
        ru_flag_reg <= 1'b1;
      else if (i_recv_unavail_clear) ru_flag_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // receive data engine
  // ---------------------------------------------------------------
  wire [10:0] size1     = desc_ctrl_reg[mhd_pkg::SIZE1_HI:mhd_pkg::SIZE1_LO];
  wire [10:0] size2     = desc_ctrl_reg[mhd_pkg::SIZE2_HI:mhd_pkg::SIZE2_LO];
  wire [10:0] cur_size  = cur_buff_reg ? size2 : size1;
  wire [10:0] buf_words = (cur_size + 11'h3) >> 2;
  wire        rx_dword  = rx_state_reg == mhd_pkg::RX_DREAD
                       && i_host_read_data_valid;
  wire        wr_accept = rx_state_reg == mhd_pkg::RX_WRITE
                       && slot_valid_reg && i_host_read_data_valid;
  wire        burst_end = burst_cnt_reg == i_burst_length_limit - 6'h1;
  wire        buff_end  = buff_cnt_reg == buf_words - 11'h1;
  wire        last_word = slot_eof_reg || buff_end || burst_end;
  wire        second_ok = !cur_buff_reg && !desc_ctrl_reg[mhd_pkg::CHAIN_BIT]
                       && size2 != 11'h0;
  wire        slot_load = rx_state_reg == mhd_pkg::RX_WRITE
                       && !slot_valid_reg && !i_recv_fifo_empty
                       && !frame_done_reg;

  // receive state transitions
  always_comb begin
    rx_state_next = rx_state_reg;
    unique case (rx_state_reg)
      mhd_pkg::RX_IDLE:
        if (!ptr_valid_reg && rx_grant) rx_state_next = mhd_pkg::RX_DREAD;
      mhd_pkg::RX_DREAD:
        if (rx_dword && dword_cnt_reg == mhd_pkg::DESC_LAST_WORD)
          rx_state_next = mhd_pkg::RX_PAUSE;
      mhd_pkg::RX_PAUSE:
        if (!desc_status_reg[mhd_pkg::OWN_BIT])
          rx_state_next = mhd_pkg::RX_IDLE;
        else if (!i_recv_fifo_empty && !own_rx_reg && rx_grant)
          rx_state_next = mhd_pkg::RX_WRITE;
      mhd_pkg::RX_WRITE:
        if (wr_accept && last_word) begin
          if (slot_eof_reg) rx_state_next = mhd_pkg::RX_STAT;
          else if (buff_end)
            rx_state_next = second_ok ? mhd_pkg::RX_PAUSE : mhd_pkg::RX_DWB;
          else rx_state_next = mhd_pkg::RX_PAUSE;
        end
      mhd_pkg::RX_STAT:
        if (!i_recv_fifo_empty) rx_state_next = mhd_pkg::RX_DWB;
      mhd_pkg::RX_DWB:
        if (rx_grant && i_host_read_data_valid)
          rx_state_next = mhd_pkg::RX_IDLE;
      default: rx_state_next = mhd_pkg::RX_IDLE;
    endcase
  end

  // descriptor capture and counters
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_reg    <= mhd_pkg::RX_IDLE;
      desc_status_reg <= mhd_pkg::WORD_RESET;
      desc_ctrl_reg   <= mhd_pkg::WORD_RESET;
      buf_addr_reg    <= mhd_pkg::ADDR_RESET;
      dword_cnt_reg   <= 2'h0;
      burst_cnt_reg   <= 6'h0;
      buff_cnt_reg    <= 11'h0;
      frame_words_reg <= 14'h0;
      cur_buff_reg    <= 1'b0;
      frame_done_reg  <= 1'b0;
    end else begin
      rx_state_reg <= rx_state_next;
      if (rx_state_reg == mhd_pkg::RX_IDLE) begin
        dword_cnt_reg   <= 2'h0;
        buff_cnt_reg    <= 11'h0;
        frame_words_reg <= 14'h0;
        cur_buff_reg    <= 1'b0;
        frame_done_reg  <= 1'b0;
      end
      if (rx_dword) begin
        dword_cnt_reg <= dword_cnt_reg + 2'h1;
        unique case (dword_cnt_reg)
          2'h0:    desc_status_reg <= i_host_read_word;
          2'h1:    desc_ctrl_reg   <= i_host_read_word;
          default: buf_addr_reg    <= i_host_read_word;
        endcase
      end
      if (rx_state_reg == mhd_pkg::RX_PAUSE) burst_cnt_reg <= 6'h0;
      if (wr_accept) begin
        burst_cnt_reg   <= burst_cnt_reg + 6'h1;
        buff_cnt_reg    <= buff_end ? 11'h0 : buff_cnt_reg + 11'h1;
        frame_words_reg <= frame_words_reg + 14'h1;
        buf_addr_reg    <= buf_addr_reg + 32'h4;
        frame_done_reg  <= slot_eof_reg;
        if (buff_end && !slot_eof_reg && second_ok) cur_buff_reg <= 1'b1;
      end
    end
  end

  // word slot between fifo and host bus
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_valid_reg <= 1'b0;
      slot_word_reg  <= mhd_pkg::WORD_RESET;
      slot_eof_reg   <= 1'b0;
    end else if (slot_load) begin
      slot_valid_reg <= 1'b1;
      slot_word_reg  <= i_recv_fifo_word;
      slot_eof_reg   <= i_recv_fifo_eof;
    end else if (wr_accept) begin
      slot_valid_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // host bus request mux
  // ---------------------------------------------------------------
  wire [31:0] wb_word = {1'b0, 1'b0, frame_words_reg, 16'h0000};
  wire [31:0] rd_addr = ds_addr_reg + {28'h0, dword_cnt_reg, 2'b00};

  always_comb begin
    o_host_req = '{mhd_pkg::CMD_IDLE, mhd_pkg::ADDR_RESET,
                   mhd_pkg::WORD_RESET, 1'b0};
    if (ds_state_reg == mhd_pkg::DS_READ && own_ds_reg)
      o_host_req = '{mhd_pkg::CMD_READ, ds_addr_reg,
                     mhd_pkg::WORD_RESET, 1'b1};
    else if (rx_state_reg == mhd_pkg::RX_DREAD && own_rx_reg)
      o_host_req = '{mhd_pkg::CMD_READ, rd_addr, mhd_pkg::WORD_RESET,
                     dword_cnt_reg == mhd_pkg::DESC_LAST_WORD};
    else if (rx_state_reg == mhd_pkg::RX_WRITE && slot_valid_reg)
      o_host_req = '{mhd_pkg::CMD_WRITE, buf_addr_reg, slot_word_reg,
                     last_word};
    else if (rx_state_reg == mhd_pkg::RX_DWB && own_rx_reg)
      o_host_req = '{mhd_pkg::CMD_WRITE, ds_addr_reg, wb_word, 1'b1};
  end

  assign o_recv_fifo_read                 = slot_load;
  assign o_receive_buffer_unavailable_flag = ru_flag_reg;
  assign o_recv_desc_request              = ds_req;

  // ---------------------------------------------------------------
  // transmit fifo stage and jabber flag
  // ---------------------------------------------------------------
  logic jabber_reg;

  assign o_xmit_word_ready = !i_xmit_fifo_full;

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_xmit_fifo_write       <= 1'b0;
      o_xmit_fifo_word        <= mhd_pkg::WORD_RESET;
      o_xmit_fifo_sof         <= 1'b0;
      o_xmit_fifo_eof         <= 1'b0;
      o_xmit_insert_checksum  <= 1'b0;
      o_xmit_insert_pad       <= 1'b0;
      o_xmit_frame_error_flag <= 1'b0;
    end else begin
      o_xmit_fifo_write <= i_xmit_word_valid && !i_xmit_fifo_full;
      o_xmit_fifo_word  <= i_xmit_word;
      o_xmit_fifo_sof   <= i_xmit_sof;
      o_xmit_fifo_eof   <= i_xmit_eof;
      o_xmit_insert_checksum <= i_xmit_sof && i_xmit_want_checksum;
      o_xmit_insert_pad      <= i_xmit_sof && i_xmit_want_pad;
      o_xmit_frame_error_flag <= i_xmit_eof && i_xmit_error;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) jabber_reg <= 1'b0;
    else if (i_xmit_jabber_event) jabber_reg <= 1'b1;
    else if (i_soft_reset) jabber_reg <= 1'b0;
  end

  assign o_xmit_jabber_timeout_flag = jabber_reg;

  // ---------------------------------------------------------------
  // clock gate enables
  // ---------------------------------------------------------------
  // activity enables
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_recv_engine_clock_gate <= 1'b0;
      o_desc_fetch_clock_gate  <= 1'b0;
      o_xmit_clock_gate        <= 1'b0;
    end else begin
      o_recv_engine_clock_gate <= rx_state_next != mhd_pkg::RX_IDLE
                               || rx_req;
      o_desc_fetch_clock_gate  <= ds_state_next == mhd_pkg::DS_MAIN
                               || ds_state_next == mhd_pkg::DS_READ;
      o_xmit_clock_gate        <= i_xmit_word_valid || o_xmit_fifo_write;
    end
  end

endmodule

`default_nettype wire

// >>> verification/mhd_props.sv
`timescale 1ns/100ps
`default_nettype none

module mhd_props (
  input wire logic                      i_sys_clk,
  input wire logic                      i_rstn,
  input wire mhd_pkg::mhd_host_req_type o_host_req,
  input wire logic                      i_host_read_data_valid,
  input wire logic [31:0]               i_host_read_word,
  input wire logic                      o_recv_desc_request,
  input wire logic                      o_receive_buffer_unavailable_flag,
  input wire logic                      i_xmit_word_valid,
  input wire logic                      o_xmit_word_ready,
  input wire logic                      i_xmit_sof,
  input wire logic                      i_xmit_want_checksum,
  input wire logic                      o_xmit_fifo_sof,
  input wire logic                      o_xmit_fifo_eof,
  input wire logic                      o_xmit_insert_checksum,
  input wire logic                      o_xmit_insert_pad,
  input wire logic                      o_xmit_frame_error_flag,
  input wire logic                      i_xmit_jabber_event,
  input wire logic                      i_soft_reset,
  input wire logic                      o_xmit_jabber_timeout_flag
);
  // edges since release
  logic [1:0] up_reg;
  wire        live = (up_reg == 2'h3);
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) up_reg <= 2'h0;
    else if (!live) up_reg <= up_reg + 2'h1;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // fetch answer, tx start
  sequence s_fetch_done;
    o_recv_desc_request && i_host_read_data_valid && o_host_req.final_word
    && o_host_req.cmd == mhd_pkg::CMD_READ && !o_host_req.addr[3];
  endsequence
  sequence s_sof_take;
    live && i_xmit_word_valid && o_xmit_word_ready && i_xmit_sof;
  endsequence
  property p_fetch_drop;
    s_fetch_done |=> !o_recv_desc_request;
  endproperty
  a_fetch_drop: assert property (p_fetch_drop)
    else $error("fetch request held");
  property p_fetch_susp;
    s_fetch_done ##0 !i_host_read_word[31] |=> o_receive_buffer_unavailable_flag;
  endproperty
  a_fetch_susp: assert property (p_fetch_susp)
    else $error("unavailable flag low");
  property p_req_stand;
    live && o_host_req.cmd != mhd_pkg::CMD_IDLE && !i_host_read_data_valid
    |=> $stable(o_host_req.cmd) && $stable(o_host_req.addr);
  endproperty
  a_req_stand: assert property (p_req_stand)
    else $error("request moved early");
  property p_sof_marks;
    s_sof_take |=> o_xmit_insert_checksum == $past(i_xmit_want_checksum);
  endproperty
  a_sof_marks: assert property (p_sof_marks)
    else $error("checksum mark lost");
  property p_nosof;
    !o_xmit_fifo_sof |-> !o_xmit_insert_checksum && !o_xmit_insert_pad;
  endproperty
  a_nosof: assert property (p_nosof)
    else $error("marks off start word");
  property p_noeof;
    !o_xmit_fifo_eof |-> !o_xmit_frame_error_flag;
  endproperty
  a_noeof: assert property (p_noeof)
    else $error("error mark off end word");
  property p_jab_set;
    live && i_xmit_jabber_event |=> o_xmit_jabber_timeout_flag;
  endproperty
  a_jab_set: assert property (p_jab_set)
    else $error("jabber flag not set");
  property p_jab_clr;
    live && i_soft_reset && !i_xmit_jabber_event
    |=> !o_xmit_jabber_timeout_flag;
  endproperty
  a_jab_clr: assert property (p_jab_clr)
    else $error("jabber flag not cleared");
endmodule

`default_nettype wire

// >>> verification/mhd_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module mhd_host_model (
  input  wire logic                      i_clk,
  input  wire logic                      i_rstn,
  input  wire mhd_pkg::mhd_host_req_type i_req,
  input  wire logic [3:0]                i_lat,
  output logic                           o_valid,
  output logic [31:0]                    o_word
);
  logic [31:0] mem [64];
  logic [3:0]  wait_reg;
  wire         take = (i_req.cmd != mhd_pkg::CMD_IDLE) && !o_valid;
  wire         done = take && (wait_reg == i_lat);
  wire  [5:0]  idx  = i_req.addr[7:2];
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_reg <= 4'h0;
      o_valid  <= 1'b0;
      o_word   <= 32'h0;
    end else begin
      o_valid  <= done;
      wait_reg <= (take && !done) ? wait_reg + 4'h1 : 4'h0;
      if (done && i_req.cmd == mhd_pkg::CMD_READ) o_word <= mem[idx];
      else o_word <= ~o_word; // released bus toggles
      if (done && i_req.cmd == mhd_pkg::CMD_WRITE) mem[idx] <= i_req.wdata;
    end
  end
endmodule

`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic i_sys_clk, i_rstn, i_host_read_data_valid, i_recv_fifo_empty;
  logic i_recv_fifo_final_read, i_recv_fifo_eof, i_receive_start_control;
  logic i_receive_poll_demand, i_recv_internal_poll_event;
  logic i_recv_unavail_clear, i_xmit_word_valid, i_xmit_sof, i_xmit_eof;
  logic i_xmit_want_checksum, i_xmit_want_pad, i_xmit_error;
  logic i_xmit_fifo_full, i_xmit_jabber_event, i_soft_reset;
  logic o_recv_fifo_read, o_receive_buffer_unavailable_flag;
  logic o_recv_desc_request, o_recv_engine_clock_gate;
  logic o_desc_fetch_clock_gate, o_xmit_clock_gate, o_xmit_word_ready;
  logic o_xmit_fifo_write, o_xmit_fifo_sof, o_xmit_fifo_eof;
  logic o_xmit_insert_checksum, o_xmit_insert_pad;
  logic o_xmit_frame_error_flag, o_xmit_jabber_timeout_flag;
  logic [31:0] i_host_read_word, i_recv_fifo_word, i_xmit_word;
  logic [31:0] o_xmit_fifo_word;
  logic [29:0] i_receive_list_base;
  logic [4:0]  i_desc_address_step;
  logic [5:0]  i_burst_length_limit;
  logic [3:0]  host_lat;
  mhd_pkg::mhd_host_req_type o_host_req;
  int          err_total = 0;
  int          total_checks = 0;

  mhd_top dut (.*);
  mhd_host_model host (
    .i_clk   (i_sys_clk),
    .i_rstn  (i_rstn),
    .i_req   (o_host_req),
    .i_lat   (host_lat),
    .o_valid (i_host_read_data_valid),
    .o_word  (i_host_read_word)
  );

  // clock
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic do_reset(input logic [31:0] desc0, input logic stop);
    @(posedge i_sys_clk);
    i_rstn <= 1'b0;
    i_receive_start_control <= stop;
    repeat (10) @(posedge i_sys_clk);
    host.mem[16] = desc0;
    i_rstn <= 1'b1;
  endtask
  // bounded wait for fetch answer
  task automatic wait_fetch(output logic [31:0] adr);
    int n;
    for (n = 0; n < 200; n++) begin
      @(negedge i_sys_clk);
      if (o_recv_desc_request && i_host_read_data_valid &&
          o_host_req.final_word && o_host_req.addr[3:0] === 4'h0 &&
          o_host_req.cmd === mhd_pkg::CMD_READ) break;
    end
    adr = o_host_req.addr;
    if (n == 200) begin
      err_total++;
      end_sim();
    end
  endtask

  // scenarios
  initial begin
    logic [31:0] adr;
    int          k;
    {i_rstn, i_recv_fifo_final_read, i_recv_fifo_eof, i_receive_start_control,
     i_receive_poll_demand, i_recv_internal_poll_event, i_recv_unavail_clear,
     i_xmit_word_valid, i_xmit_sof, i_xmit_eof, i_xmit_want_checksum,
     i_xmit_want_pad, i_xmit_error, i_xmit_fifo_full, i_xmit_jabber_event,
     i_soft_reset, i_recv_fifo_word, i_xmit_word} = '0;
    i_recv_fifo_empty = 1'b1;
    i_receive_list_base = 30'h10;
    i_desc_address_step = 5'h3;
    i_burst_length_limit = 6'h4;
    host_lat = 4'h0;
    for (k = 0; k < 64; k++) host.mem[k] = 32'h0;
    // owned descriptor
    do_reset(32'h8000_0000, 1'b0);
    wait_fetch(adr);
    chk(adr, {i_receive_list_base, 2'b00});
    @(negedge i_sys_clk);
    chk(32'(o_recv_desc_request), 32'h0);
    chk(32'(o_receive_buffer_unavailable_flag), 32'h0);
    // host-owned, slow host: suspend, poll
    host_lat <= 4'h3;
    do_reset(32'h0, 1'b0);
    for (k = 0; k < 2; k++) begin
      wait_fetch(adr);
      @(negedge i_sys_clk);
      chk(32'(o_receive_buffer_unavailable_flag), 32'h1);
      chk(32'(o_recv_desc_request), 32'h0);
      @(posedge i_sys_clk);
      i_recv_unavail_clear <= 1'b1;
      i_receive_poll_demand <= (k == 0);
      i_recv_internal_poll_event <= (k == 1);
      @(posedge i_sys_clk);
      {i_recv_unavail_clear, i_receive_poll_demand} <= 2'h0;
      i_recv_internal_poll_event <= 1'b0;
      @(negedge i_sys_clk);
      chk(32'(o_recv_desc_request), 32'h1);
      chk(32'(o_receive_buffer_unavailable_flag), 32'h0);
    end
    // tx words, all four sof/eof combinations
    for (k = 0; k < 4; k++) begin
      @(posedge i_sys_clk);
      i_xmit_word_valid <= 1'b1;
      i_xmit_word <= 32'hA5A5_0000 + 32'(k);
      {i_xmit_sof, i_xmit_eof} <= 2'(k);
      {i_xmit_want_checksum, i_xmit_want_pad, i_xmit_error} <= 3'h7;
      @(posedge i_sys_clk);
      i_xmit_word_valid <= 1'b0;
      @(negedge i_sys_clk);
      chk(32'(o_xmit_fifo_write), 32'h1);
      chk(o_xmit_fifo_word, 32'hA5A5_0000 + 32'(k));
      chk(32'(o_xmit_insert_checksum), 32'(k[1]));
      chk(32'(o_xmit_insert_pad), 32'(k[1]));
      chk(32'(o_xmit_frame_error_flag), 32'(k[0]));
    end
    // full tx fifo refuses the word
    @(posedge i_sys_clk);
    {i_xmit_word_valid, i_xmit_fifo_full} <= 2'h3;
    @(negedge i_sys_clk);
    chk(32'(o_xmit_word_ready), 32'h0);
    @(negedge i_sys_clk);
    chk(32'(o_xmit_fifo_write), 32'h0);
    @(posedge i_sys_clk);
    {i_xmit_word_valid, i_xmit_fifo_full} <= 2'h0;
    // jabber set, clear, set wins
    for (k = 0; k < 3; k++) begin
      @(posedge i_sys_clk);
      i_xmit_jabber_event <= (k != 1);
      i_soft_reset <= (k != 0);
      @(posedge i_sys_clk);
      {i_xmit_jabber_event, i_soft_reset} <= 2'h0;
      @(negedge i_sys_clk);
      chk(32'(o_xmit_jabber_timeout_flag), 32'(k != 1));
    end
    // receive stopped until start drops
    do_reset(32'h8000_0000, 1'b1);
    repeat (20) @(negedge i_sys_clk);
    chk(32'(o_recv_desc_request), 32'h0);
    @(posedge i_sys_clk);
    i_receive_start_control <= 1'b0;
    repeat (2) @(negedge i_sys_clk);
    chk(32'(o_recv_desc_request), 32'h1);
    end_sim();
  end
endmodule

bind mhd_top mhd_props u_props (.*);

`default_nettype wire
